// File: verification/test_timer_counter_modulo_channel_flags.sv
// Purpose: self-checking bench of the timer counter block
// Assumes: bus master model drives all register traffic
// Notes: fixed_tick is pulsed by hand so every count is known exactly
`timescale 1ns/100ps
`include "tmc_defines.svh"

module test_timer_counter_modulo_channel_flags;
	logic clk, rstn, debug_halt, fixed_tick, ext_tick;
	logic [`TMC_AW-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, overflow_irq;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] rresp, rr, channel_pin, channel_irq, bresp;
	integer fail_count, checks;

	tmc_timer tmc_timer_i (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .debug_halt(debug_halt), .fixed_tick(fixed_tick), .ext_tick(ext_tick),
		.channel_pin(channel_pin), .overflow_irq(overflow_irq), .channel_irq(channel_irq));
	tmc_bus_master bus_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ======================================================================
	// Helpers
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(input logic [`TMC_AW-1:0] a, input logic [7:0] e);
		bus_i.rd(a, rv, rr);
		chk($sformatf("reg %h", a), rv, {24'h0, e});
	endtask
	// Pulses are spaced so each one is a separate count event; both sources pulse, only one is selected
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			{fixed_tick, ext_tick} <= 2'b11;
			@(posedge clk);
			{fixed_tick, ext_tick} <= 2'b00;
		end
	endtask
	task automatic halt(input logic v);
		@(posedge clk);
		debug_halt <= v;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#500000;
		fail_count++;
		results();
	end

	// ======================================================================
	// Test sequence
	initial begin
		{rstn, debug_halt, fixed_tick, ext_tick, channel_pin} = '0;
		fail_count = 0;
		checks = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rchk(`TMC_OFF_MOD_LO, 8'h00);
		rchk(`TMC_OFF_CH0_SC, 8'h00);
		bus_i.rd(6'h3c, rv, rr);
		chk("unmapped resp", {30'h0, rr}, {30'h0, `TMC_RESP_SLVERR});
		bus_i.wr(6'h3c, 16'h00);
		chk("unmapped wresp", {30'h0, bus_i.last_bresp}, {30'h0, `TMC_RESP_SLVERR});
		// Coherent counter reads, count from fixed ticks
		bus_i.wr(`TMC_OFF_SC, 16'h10);
		chk("write resp", {30'h0, bus_i.last_bresp}, {30'h0, `TMC_RESP_OKAY});
		ticks(3);
		rchk(`TMC_OFF_CNT_LO, 8'h03);
		ticks(2);
		rchk(`TMC_OFF_CNT_LO, 8'h03);
		rchk(`TMC_OFF_CNT_HI, 8'h00);
		rchk(`TMC_OFF_CNT_LO, 8'h05);
		ticks(1);
		bus_i.wr(`TMC_OFF_SC, 16'h10);
		rchk(`TMC_OFF_CNT_LO, 8'h06);
		rchk(`TMC_OFF_CNT_HI, 8'h00);
		ticks(1);
		bus_i.wr(`TMC_OFF_CNT_HI, 16'hab);
		rchk(`TMC_OFF_CNT_LO, 8'h00);
		rchk(`TMC_OFF_CNT_HI, 8'h00);
		// Halt: no counting, reads in halt leave the held byte alone
		ticks(2);
		rchk(`TMC_OFF_CNT_LO, 8'h02);
		halt(1'b1);
		ticks(2);
		rchk(`TMC_OFF_CNT_HI, 8'h00);
		halt(1'b0);
		ticks(1);
		rchk(`TMC_OFF_CNT_LO, 8'h02);
		rchk(`TMC_OFF_CNT_HI, 8'h00);
		rchk(`TMC_OFF_CNT_LO, 8'h03);
		halt(1'b1);
		bus_i.wr(`TMC_OFF_CNT_LO, 16'h00);
		bus_i.wr(`TMC_OFF_MOD_HI, 16'h00);
		bus_i.wr(`TMC_OFF_MOD_LO, 16'h04);
		rchk(`TMC_OFF_MOD_LO, 8'h04);
		halt(1'b0);
		ticks(1);
		rchk(`TMC_OFF_CNT_LO, 8'h01);
		rchk(`TMC_OFF_CNT_HI, 8'h00);
		// Overflow at modulo 4, cleared before modulo use
		bus_i.wr(`TMC_OFF_CNT_LO, 16'h00);
		bus_i.wr(`TMC_OFF_SC, 16'h50);
		ticks(4);
		rchk(`TMC_OFF_SC, 8'h50);
		ticks(1);
		rchk(`TMC_OFF_SC, 8'hd0);
		chk("overflow_irq", {31'h0, overflow_irq}, 32'h1);
		bus_i.wr(`TMC_OFF_SC, 16'h50);
		rchk(`TMC_OFF_SC, 8'h50);
		chk("overflow_irq", {31'h0, overflow_irq}, 32'h0);
		bus_i.wr(`TMC_OFF_MOD_HI, 16'h00);
		ticks(5);
		rchk(`TMC_OFF_SC, 8'h50);
		bus_i.wr(`TMC_OFF_SC, 16'h50);
		ticks(5);
		rchk(`TMC_OFF_SC, 8'hd0);
		// Clock off: no counting, modulo loads at second byte
		bus_i.wr(`TMC_OFF_SC, 16'h00);
		ticks(2);
		rchk(`TMC_OFF_CNT_LO, 8'h00);
		rchk(`TMC_OFF_CNT_HI, 8'h00);
		bus_i.wr(`TMC_OFF_MOD_HI, 16'h00);
		bus_i.wr(`TMC_OFF_MOD_LO, 16'h02);
		rchk(`TMC_OFF_MOD_LO, 8'h02);
		// Clock on: new modulo 3 only takes hold at the step into old terminal
		bus_i.wr(`TMC_OFF_SC, 16'h10);
		bus_i.wr(`TMC_OFF_MOD_HI, 16'h00);
		bus_i.wr(`TMC_OFF_MOD_LO, 16'h03);
		rchk(`TMC_OFF_MOD_LO, 8'h02);
		ticks(3);
		rchk(`TMC_OFF_CNT_LO, 8'h03);
		rchk(`TMC_OFF_CNT_HI, 8'h00);
		// Channel 0 capture on rising edge, flag clear sequence
		bus_i.wr(`TMC_OFF_CH0_SC, 16'h44);
		@(posedge clk);
		channel_pin <= 2'b01;
		rchk(`TMC_OFF_CH0_SC, 8'hc4);
		chk("channel_irq", {30'h0, channel_irq}, 32'h1);
		bus_i.wr(`TMC_OFF_CH0_SC, 16'hc4);
		rchk(`TMC_OFF_CH0_SC, 8'hc4);
		bus_i.wr(`TMC_OFF_CH0_SC, 16'h44);
		rchk(`TMC_OFF_CH0_SC, 8'h44);
		chk("channel_irq", {30'h0, channel_irq}, 32'h0);
		// Channel 1 compare match, then PWM at zero duty
		bus_i.wr(`TMC_OFF_CNT_LO, 16'h00);
		bus_i.wr(`TMC_OFF_CH1_VAL, 16'h0002);
		bus_i.wr(`TMC_OFF_CH1_SC, 16'h14);
		ticks(2);
		rchk(`TMC_OFF_CH1_SC, 8'h94);
		bus_i.wr(`TMC_OFF_CH1_SC, 16'h28);
		bus_i.wr(`TMC_OFF_CH1_VAL, 16'h0000);
		ticks(2);
		rchk(`TMC_OFF_CH1_SC, 8'h28);
		// External source through divide-by-2: four pulses give two steps
		bus_i.wr(`TMC_OFF_SC, 16'h19);
		ticks(4);
		rchk(`TMC_OFF_CNT_LO, 8'h02);
		results();
	end
endmodule

// File: verification/tmc_bus_master.sv
// Purpose: processor-side bus master model for the timer block
// Assumes: AXI4-Lite, one write and one read at a time
// Notes: after the idle values at time zero, bus outputs change by non-blocking assignment just after a rising edge
`timescale 1ns/100ps
`include "tmc_defines.svh"

module tmc_bus_master (
	// Clock
	input wire logic clk,
	// Write channels
	output logic [`TMC_AW-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [`TMC_AW-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// Response code of the last write, taken at the edge that shows bvalid
	logic [1:0] last_bresp;

	// Idle bus from time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	end

	// ======================================================================
	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [`TMC_AW-1:0] a, input logic [15:0] d);
		logic ta;
		logic td;
		ta = 1'b0;
		td = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && td)) begin
			@(posedge clk);
			if (awready && !ta) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !td) begin
				td = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// No cycle count assumed, the response is simply awaited
		do @(posedge clk); while (!bvalid);
		last_bresp = bresp;
		bready <= 1'b0;
	endtask

	// ======================================================================
	// Read: data and response taken at the edge that shows rvalid
	task automatic rd(input logic [`TMC_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

// File: verilog/tmc_channel.sv
// Purpose: one timer channel: control byte, value register, event flag, request
// Assumes: pin input synchronous to clk; counter step pulse from the top
// Notes: only flag and enable behaviour plus simple capture and match
`timescale 1ns/100ps
`include "tmc_defines.svh"

module tmc_channel (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Counter view
	input wire logic count_step,
	input wire tmc_pkg::tmc_word_t cnt_next,
	input wire tmc_pkg::tmc_word_t cnt_now,
	input wire tmc_pkg::tmc_word_t mod_now,
	// Register access
	input wire logic sc_rd,
	input wire logic sc_wr,
	input wire logic val_wr,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// Pin and outputs
	input wire logic pin_in,
	output tmc_pkg::tmc_byte_t sc_out,
	output tmc_pkg::tmc_word_t val_out,
	output logic irq
);
	import tmc_pkg::*;

	logic [5:0] ctrl_reg;
	logic flag_reg;
	logic armed_reg;
	logic pin_prev_reg;
	tmc_word_t val_reg;
	logic is_capture;
	logic is_pwm;
	logic edge_hit;
	logic match_hit;
	logic set_evt;

	// ======================================================================
	// Mode decode and events; ctrl_reg holds control bits 6:1, so mode is [4:3], edge is [2:1]
	assign is_capture = (ctrl_reg[4:3] == 2'h0) && (ctrl_reg[2:1] != 2'h0);
	assign is_pwm = ctrl_reg[4];
	assign edge_hit = (ctrl_reg[1] && pin_in && !pin_prev_reg) || (ctrl_reg[2] && !pin_in && pin_prev_reg);
	// Duty 0% is value zero, 100% is value past the modulo: no flag there
	assign match_hit = count_step && (cnt_next == val_reg) && !is_capture
		&& !(is_pwm && ((val_reg == 16'h0000) || ((mod_now != 16'h0000) && (val_reg > mod_now)))); // R15
	assign set_evt = (is_capture && edge_hit) || match_hit; // R14
	assign sc_out = {flag_reg, ctrl_reg, 1'b0};
	assign val_out = val_reg;

	// Pin history for edge detection
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pin_prev_reg <= 1'b0;
		end else begin
			pin_prev_reg <= pin_in;
		end
	end

	// Control bits: enable and mode
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_reg <= 6'h00; // R18
		end else if (sc_wr && wstrb[0]) begin
			ctrl_reg <= wdata[6:1];
		end
	end

	// Flag: set wins over a clear landing in the same cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			flag_reg <= 1'b0; // R18
			armed_reg <= 1'b0;
		end else if (set_evt) begin
			flag_reg <= 1'b1; // R14
			armed_reg <= 1'b0; // R17
		end else begin
			if (sc_rd && flag_reg) begin
				armed_reg <= 1'b1;
			end
			if (sc_wr && wstrb[0] && !wdata[`TMC_FLAG_BIT] && armed_reg) begin
				flag_reg <= 1'b0; // R17
				armed_reg <= 1'b0;
			end
		end
	end

	// Value: captured on edge, otherwise written by software
	always_ff @(posedge clk) begin
		if (!rstn) begin
			val_reg <= 16'h0000;
		end else if (is_capture && edge_hit) begin
			val_reg <= cnt_now;
		end else if (val_wr && !is_capture) begin
			if (wstrb[0]) val_reg[7:0] <= wdata[7:0];
			if (wstrb[1]) val_reg[15:8] <= wdata[15:8];
		end
	end

	// Request line, registered
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= flag_reg && ctrl_reg[5]; // R16
		end
	end
endmodule

// File: verilog/tmc_defines.svh
// Purpose: register offsets, field positions and reset values of the timer block
// Assumes: 32-bit AXI4-Lite words, one register per aligned word
// Notes: byte registers sit in bits 7:0 of their word, upper bits read zero
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define TMC_AW 6
`define TMC_OFF_SC 6'h00
`define TMC_OFF_CNT_HI 6'h04
`define TMC_OFF_CNT_LO 6'h08
`define TMC_OFF_MOD_HI 6'h0c
`define TMC_OFF_MOD_LO 6'h10
`define TMC_OFF_CH0_SC 6'h14
`define TMC_OFF_CH1_SC 6'h18
`define TMC_OFF_CH0_VAL 6'h1c
`define TMC_OFF_CH1_VAL 6'h20

// ==========================================================================
// Field positions
`define TMC_FLAG_BIT 7
`define TMC_IE_BIT 6
`define TMC_CLKS_HI 4
`define TMC_CLKS_LO 3
`define TMC_PS_HI 2
`define TMC_PS_LO 0

// ==========================================================================
// Reset values and constants
`define TMC_MOD_RESET 16'h0000
`define TMC_CNT_RESET 16'h0000
`define TMC_CNT_FULL 16'hffff
`define TMC_CLKS_OFF 2'h0
`define TMC_CLKS_BUS 2'h1
`define TMC_CLKS_FIXED 2'h2
`define TMC_CLKS_EXT 2'h3
`define TMC_NUM_CH 2
`define TMC_RESP_OKAY 2'h0
`define TMC_RESP_SLVERR 2'h2

`endif

// File: verilog/tmc_pkg.sv
// Purpose: shared types of the timer block
// Assumes: nothing beyond the defines header
// Notes: register selector is decoded once and used by read and write paths
package tmc_pkg;
	// ======================================================================
	// Register selector, one-hot
	typedef enum logic [8:0] {
		TMC_SEL_NONE = 9'h000,
		TMC_SEL_SC = 9'h001,
		TMC_SEL_CNT_HI = 9'h002,
		TMC_SEL_CNT_LO = 9'h004,
		TMC_SEL_MOD_HI = 9'h008,
		TMC_SEL_MOD_LO = 9'h010,
		TMC_SEL_CH0_SC = 9'h020,
		TMC_SEL_CH1_SC = 9'h040,
		TMC_SEL_CH0_VAL = 9'h080,
		TMC_SEL_CH1_VAL = 9'h100
	} tmc_sel_e;
	typedef logic [7:0] tmc_byte_t;
	typedef logic [15:0] tmc_word_t;
endpackage

// File: verilog/tmc_timer.sv
// Purpose: 16-bit timer counter with coherent byte reads, buffered modulo and two channels
// Assumes: AXI4-Lite slave at 40 MHz, debug_halt and tick inputs synchronous
// Notes: up-counting only; responses come one cycle after the request is taken
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "tmc_defines.svh"

// How it works
// R1 - Reading either counter byte freezes both in a buffer until the other byte is read.
// R2 - Reset or any status-control write releases the counter read buffer.
// R3 - Reset clears the counter; any counter byte write zeroes it and releases the buffer.
// R4 - Debug halt stops counting and freezes the read buffer state despite reads.
// R5 - During halt, status-control or counter writes still release the read buffer.
// R6 - Counter at modulo goes to zero on the next step and sets overflow flag.
// R7 - One modulo byte written blocks overflow flagging until the other byte follows.
// R8 - Reset loads modulo zero, giving a free-running full 16-bit counter.
// R9 - With the count clock off, buffered modulo applies once the second byte lands.
// R10 - With a clock on, buffered modulo applies at the step into the terminal value.
// R11 - A status-control write resets modulo byte tracking, halted or not.
// R12 - In halt, tracking stays frozen and modulo writes go straight to the register.
// R13 - Software should clear the counter before programming the modulo.
// R14 - Input-capture channel flag sets on an active pin edge.
// R15 - Compare or PWM flag sets on match, except PWM at 0% or 100% duty.
// R16 - Channel request raised while its flag and enable are both set.
// R17 - Flag clears by read-while-set then write zero; a new event restarts it.
// R18 - Reset clears channel flags and channel enables.
// R19 - Clock select zero leaves the counter without count clock.
// R20 - Overflow request raised while overflow flag and its enable are set.
// R21 - With a clock selected and no halt, counter advances once per prescaled step.
module tmc_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// AXI4-Lite write channels
	input wire logic [`TMC_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [`TMC_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Timer side
	input wire logic debug_halt,
	input wire logic fixed_tick,
	input wire logic ext_tick,
	input wire logic [`TMC_NUM_CH-1:0] channel_pin,
	// Requests
	output logic overflow_irq,
	output logic [`TMC_NUM_CH-1:0] channel_irq
);
	import tmc_pkg::*;

	// ======================================================================
	// Address decode, shared by both paths
	function automatic tmc_sel_e sel_of(input logic [`TMC_AW-1:0] a);
		case (a)
			`TMC_OFF_SC: sel_of = TMC_SEL_SC;
			`TMC_OFF_CNT_HI: sel_of = TMC_SEL_CNT_HI;
			`TMC_OFF_CNT_LO: sel_of = TMC_SEL_CNT_LO;
			`TMC_OFF_MOD_HI: sel_of = TMC_SEL_MOD_HI;
			`TMC_OFF_MOD_LO: sel_of = TMC_SEL_MOD_LO;
			`TMC_OFF_CH0_SC: sel_of = TMC_SEL_CH0_SC;
			`TMC_OFF_CH1_SC: sel_of = TMC_SEL_CH1_SC;
			`TMC_OFF_CH0_VAL: sel_of = TMC_SEL_CH0_VAL;
			`TMC_OFF_CH1_VAL: sel_of = TMC_SEL_CH1_VAL;
			default: sel_of = TMC_SEL_NONE;
		endcase
	endfunction

	logic aw_full_reg;
	logic w_full_reg;
	logic [`TMC_AW-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic aw_hs, w_hs, wr_do, rd_do;
	logic [`TMC_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	tmc_sel_e wsel, rsel;
	logic wr_en;
	logic sc_wr, cnt_wr, modh_wr, modl_wr;

	// ======================================================================
	// Bus slave: address and data may arrive in either order
	assign aw_hs = awvalid && awready;
	assign w_hs = wvalid && wready;
	assign wr_addr = aw_full_reg ? aw_addr_reg : awaddr;
	assign wr_data = w_full_reg ? w_data_reg : wdata;
	assign wr_strb = w_full_reg ? w_strb_reg : wstrb;
	assign wr_do = (aw_full_reg || aw_hs) && (w_full_reg || w_hs);
	assign rd_do = arvalid && arready;
	assign wsel = sel_of(wr_addr);
	assign rsel = sel_of(araddr);
	// Byte registers ignore writes without lane 0
	assign wr_en = wr_do && wr_strb[0];
	assign sc_wr = wr_en && (wsel == TMC_SEL_SC);
	assign cnt_wr = wr_en && ((wsel == TMC_SEL_CNT_HI) || (wsel == TMC_SEL_CNT_LO));
	assign modh_wr = wr_en && (wsel == TMC_SEL_MOD_HI);
	assign modl_wr = wr_en && (wsel == TMC_SEL_MOD_LO);

	// Write path holding and response
	always_ff @(posedge clk) begin
		if (!rstn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `TMC_RESP_OKAY;
		end else begin
			if (aw_hs) aw_addr_reg <= awaddr;
			if (w_hs) begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			aw_full_reg <= (aw_full_reg || aw_hs) && !wr_do;
			w_full_reg <= (w_full_reg || w_hs) && !wr_do;
			// Each ready drops while its own channel is held or a response is due, so one write at a time
			awready <= !((aw_full_reg || aw_hs) && !wr_do) && !(wr_do || (bvalid && !bready));
			wready <= !((w_full_reg || w_hs) && !wr_do) && !(wr_do || (bvalid && !bready));
			if (wr_do) begin
				bvalid <= 1'b1;
				bresp <= (wsel == TMC_SEL_NONE) ? `TMC_RESP_SLVERR : `TMC_RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Status/control and prescaler
	logic ovf_flag_reg, ovf_armed_reg, ovf_ie_reg;
	logic [1:0] clk_sel_reg;
	logic [2:0] ps_reg;
	logic [6:0] presc_reg;
	logic [6:0] presc_mask;
	logic src_en, tick, wrap, ovf_set, mod_half;
	tmc_word_t cnt_reg, terminal, cnt_next, mod_reg;

	always_comb begin
		case (clk_sel_reg)
			`TMC_CLKS_BUS: src_en = 1'b1;
			`TMC_CLKS_FIXED: src_en = fixed_tick;
			`TMC_CLKS_EXT: src_en = ext_tick;
			default: src_en = 1'b0; // R19
		endcase
	end
	assign presc_mask = 7'((8'h01 << ps_reg) - 8'h01);
	assign tick = src_en && !debug_halt && ((presc_reg & presc_mask) == presc_mask); // R21 R4

	// Prescaler runs only while a source is selected and not halted
	always_ff @(posedge clk) begin
		if (!rstn) begin
			presc_reg <= 7'h00;
		end else if (src_en && !debug_halt) begin
			presc_reg <= 7'(presc_reg + 7'h01);
		end
	end

	// Control fields
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ovf_ie_reg <= 1'b0;
			clk_sel_reg <= `TMC_CLKS_OFF;
			ps_reg <= 3'h0;
		end else if (sc_wr) begin
			ovf_ie_reg <= wr_data[`TMC_IE_BIT];
			clk_sel_reg <= wr_data[`TMC_CLKS_HI:`TMC_CLKS_LO];
			ps_reg <= wr_data[`TMC_PS_HI:`TMC_PS_LO];
		end
	end

	// Overflow flag: set wins; clear needs a prior read while set
	assign ovf_set = wrap && !mod_half; // R6 R7
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ovf_flag_reg <= 1'b0;
			ovf_armed_reg <= 1'b0;
		end else if (ovf_set) begin
			ovf_flag_reg <= 1'b1;
			ovf_armed_reg <= 1'b0;
		end else begin
			if (rd_do && (rsel == TMC_SEL_SC) && ovf_flag_reg) ovf_armed_reg <= 1'b1;
			if (sc_wr && !wr_data[`TMC_FLAG_BIT] && ovf_armed_reg) begin
				ovf_flag_reg <= 1'b0;
				ovf_armed_reg <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Counter and coherent read buffer
	logic cnt_latched_reg, first_hi_reg;
	tmc_word_t cnt_buf_reg;
	logic cnt_rd, cnt_rd_hi;

	// Modulo zero means free running to the top
	assign terminal = (mod_reg == 16'h0000) ? `TMC_CNT_FULL : mod_reg;
	assign wrap = tick && (cnt_reg == terminal);
	assign cnt_next = wrap ? 16'h0000 : 16'(cnt_reg + 16'h0001);
	assign cnt_rd = rd_do && ((rsel == TMC_SEL_CNT_HI) || (rsel == TMC_SEL_CNT_LO));
	assign cnt_rd_hi = (rsel == TMC_SEL_CNT_HI);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_reg <= `TMC_CNT_RESET; // R3
		end else if (cnt_wr) begin
			cnt_reg <= 16'h0000; // R3
		end else if (tick) begin
			cnt_reg <= cnt_next; // R6 R21
		end
	end

	// Release wins over a read; halt freezes the state against reads only
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_latched_reg <= 1'b0; // R2
			first_hi_reg <= 1'b0;
			cnt_buf_reg <= 16'h0000;
		end else if (sc_wr || cnt_wr) begin
			cnt_latched_reg <= 1'b0; // R2 R3 R5
		end else if (cnt_rd && !debug_halt) begin
			if (!cnt_latched_reg) begin
				cnt_latched_reg <= 1'b1; // R1
				cnt_buf_reg <= cnt_reg;
				first_hi_reg <= cnt_rd_hi;
			end else if (cnt_rd_hi != first_hi_reg) begin
				cnt_latched_reg <= 1'b0; // R1
			end
		end
	end

	// ======================================================================
	// Modulo with write buffer
	tmc_word_t mod_buf_reg, mod_apply_val;
	logic mod_hi_w_reg, mod_lo_w_reg;
	logic mod_both, mod_apply_now, mod_apply_step;

	assign mod_half = mod_hi_w_reg ^ mod_lo_w_reg;
	assign mod_both = (mod_hi_w_reg || modh_wr) && (mod_lo_w_reg || modl_wr);
	assign mod_apply_val = {modh_wr ? wr_data[7:0] : mod_buf_reg[15:8], modl_wr ? wr_data[7:0] : mod_buf_reg[7:0]};
	assign mod_apply_now = !debug_halt && !sc_wr && (modh_wr || modl_wr) && mod_both
		&& (clk_sel_reg == `TMC_CLKS_OFF); // R9
	assign mod_apply_step = !debug_halt && mod_hi_w_reg && mod_lo_w_reg && tick
		&& (cnt_reg == 16'(terminal - 16'h0001)); // R10

	always_ff @(posedge clk) begin
		if (!rstn) begin
			mod_reg <= `TMC_MOD_RESET; // R8
		end else if (debug_halt && modh_wr) begin
			mod_reg[15:8] <= wr_data[7:0]; // R12
		end else if (debug_halt && modl_wr) begin
			mod_reg[7:0] <= wr_data[7:0]; // R12
		end else if (mod_apply_now) begin
			mod_reg <= mod_apply_val; // R9
		end else if (mod_apply_step) begin
			mod_reg <= mod_buf_reg; // R10
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			mod_buf_reg <= `TMC_MOD_RESET;
			mod_hi_w_reg <= 1'b0;
			mod_lo_w_reg <= 1'b0;
		end else if (sc_wr) begin
			mod_hi_w_reg <= 1'b0; // R11
			mod_lo_w_reg <= 1'b0;
		end else if (!debug_halt) begin
			// Tracking frozen in halt: writes there bypass the buffer
			mod_buf_reg <= mod_apply_val;
			if (mod_apply_now || mod_apply_step) begin
				mod_hi_w_reg <= 1'b0;
				mod_lo_w_reg <= 1'b0;
			end else begin
				mod_hi_w_reg <= mod_hi_w_reg || modh_wr;
				mod_lo_w_reg <= mod_lo_w_reg || modl_wr;
			end
		end
	end

	// ======================================================================
	// Channels
	tmc_byte_t ch_sc [`TMC_NUM_CH];
	tmc_word_t ch_val [`TMC_NUM_CH];
	genvar gi;
	generate
		for (gi = 0; gi < `TMC_NUM_CH; gi++) begin : g_ch
			tmc_channel u_ch (
				.clk(clk),
				.rstn(rstn),
				.count_step(tick),
				.cnt_next(cnt_next),
				.cnt_now(cnt_reg),
				.mod_now(mod_reg),
				.sc_rd(rd_do && (rsel == tmc_sel_e'(TMC_SEL_CH0_SC << gi))),
				.sc_wr(wr_do && (wsel == tmc_sel_e'(TMC_SEL_CH0_SC << gi))),
				.val_wr(wr_do && (wsel == tmc_sel_e'(TMC_SEL_CH0_VAL << gi))),
				.wdata(wr_data),
				.wstrb(wr_strb),
				.pin_in(channel_pin[gi]),
				.sc_out(ch_sc[gi]),
				.val_out(ch_val[gi]),
				.irq(channel_irq[gi])
			);
		end
	endgenerate

	// ======================================================================
	// Read path; counter bytes come from the buffer while it holds and debug_halt is low
	tmc_word_t cnt_view;
	assign cnt_view = (cnt_latched_reg && !debug_halt) ? cnt_buf_reg : cnt_reg;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `TMC_RESP_OKAY;
		end else begin
			arready <= !(rd_do || (rvalid && !rready));
			if (rd_do) begin
				rvalid <= 1'b1;
				rresp <= (rsel == TMC_SEL_NONE) ? `TMC_RESP_SLVERR : `TMC_RESP_OKAY;
				case (rsel)
					TMC_SEL_SC: rdata <= {24'h0, ovf_flag_reg, ovf_ie_reg, 1'b0, clk_sel_reg, ps_reg};
					TMC_SEL_CNT_HI: rdata <= {24'h0, cnt_view[15:8]};
					TMC_SEL_CNT_LO: rdata <= {24'h0, cnt_view[7:0]};
					TMC_SEL_MOD_HI: rdata <= {24'h0, mod_reg[15:8]};
					TMC_SEL_MOD_LO: rdata <= {24'h0, mod_reg[7:0]};
					TMC_SEL_CH0_SC: rdata <= {24'h0, ch_sc[0]};
					TMC_SEL_CH1_SC: rdata <= {24'h0, ch_sc[1]};
					TMC_SEL_CH0_VAL: rdata <= {16'h0, ch_val[0]};
					TMC_SEL_CH1_VAL: rdata <= {16'h0, ch_val[1]};
					default: rdata <= 32'h0000_0000;
				endcase
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Overflow request, registered
	always_ff @(posedge clk) begin
		if (!rstn) begin
			overflow_irq <= 1'b0;
		end else begin
			overflow_irq <= ovf_flag_reg && ovf_ie_reg; // R20
		end
	end

	// ======================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_read_holds_buf: assert property (cnt_rd && !debug_halt && !cnt_latched_reg && !sc_wr && !cnt_wr
		|=> cnt_latched_reg && cnt_buf_reg == $past(cnt_reg)) else $error("read did not latch counter"); // R1
	a_sc_releases: assert property (sc_wr |=> !cnt_latched_reg && !mod_hi_w_reg && !mod_lo_w_reg)
		else $error("control write left latches set"); // R2
	a_cnt_write_clr: assert property (cnt_wr |=> cnt_reg == 16'h0000 && !cnt_latched_reg)
		else $error("counter write did not clear"); // R3
	a_halt_frozen: assert property (debug_halt && !sc_wr && !cnt_wr |=> $stable(cnt_reg) && $stable(cnt_latched_reg))
		else $error("counter moved during halt"); // R4
	a_wrap_flags: assert property (wrap && !mod_half && !cnt_wr |=> cnt_reg == 16'h0000 && ovf_flag_reg)
		else $error("wrap did not set overflow"); // R6
	a_half_mod_quiet: assert property (wrap && mod_half && !ovf_flag_reg |=> !ovf_flag_reg)
		else $error("overflow set with half modulo"); // R7
	a_mod_stop_load: assert property (mod_apply_now |=> mod_reg == $past(mod_apply_val))
		else $error("modulo not loaded while stopped"); // R9
	a_off_no_count: assert property (clk_sel_reg == `TMC_CLKS_OFF && !cnt_wr |=> $stable(cnt_reg))
		else $error("counter moved with no clock"); // R19
	a_ovf_request: assert property (ovf_flag_reg && ovf_ie_reg ##1 ovf_flag_reg |-> overflow_irq)
		else $error("overflow request missing"); // R20
	a_count_step: assert property (tick && !wrap && !cnt_wr |=> cnt_reg == $past(cnt_reg) + 16'h0001)
		else $error("counter did not step"); // R21
	a_clear_needs_arm: assert property (ovf_flag_reg && !ovf_armed_reg && !ovf_set |=> ovf_flag_reg)
		else $error("overflow cleared without read"); // R17

	c_wrap: cover property (ovf_set);
	c_coherent_pair: cover property (cnt_rd && !cnt_latched_reg ##[1:20] cnt_rd && cnt_latched_reg);
	c_mod_run_load: cover property (mod_apply_step);
	c_ovf_cleared: cover property (ovf_flag_reg ##1 !ovf_flag_reg);
endmodule
